/* rtl/pwtfc_defs.svh */
/*
 pulse width trigger and frequency counter: timing figures and derived counts.
 assumes a single 250 MHz system clock; included by bare name.
*/
`ifndef PWTFC_DEFS_SVH
`define PWTFC_DEFS_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define PWTFC_CLK_PS 64'd4000

// ----------------------------------------
// width setting limits and step
// ----------------------------------------
`define PWTFC_MIN_PS 64'd33000
`define PWTFC_MAX_S 64'd10
`define PWTFC_STEP_PS 64'd16500
`define PWTFC_MIN_CYC 32'((`PWTFC_MIN_PS + `PWTFC_CLK_PS - 64'd1) / `PWTFC_CLK_PS)
`define PWTFC_MAX_CYC 32'(`PWTFC_MAX_S * 64'd1000000000000 / `PWTFC_CLK_PS)
`define PWTFC_STEP_CYC 32'(`PWTFC_STEP_PS / `PWTFC_CLK_PS)

// ----------------------------------------
// tolerance band corners
// ----------------------------------------
`define PWTFC_LONG_PS 64'd330000
`define PWTFC_MID_PS 64'd165000
`define PWTFC_NE_HI_PS 64'd33000
`define PWTFC_LONG_CYC 32'(`PWTFC_LONG_PS / `PWTFC_CLK_PS)
`define PWTFC_MID_CYC 32'(`PWTFC_MID_PS / `PWTFC_CLK_PS)
`define PWTFC_NE_HI_CYC 32'(`PWTFC_NE_HI_PS / `PWTFC_CLK_PS)
`define PWTFC_PCT_DIV 32'd20
`define PWTFC_PPT_SHIFT 10

// ----------------------------------------
// frequency counter gate
// ----------------------------------------
`define PWTFC_GATE_MS 64'd250
`define PWTFC_GATE_CYC 32'(`PWTFC_GATE_MS * 64'd1000000000 / `PWTFC_CLK_PS)

`endif

/* rtl/pwtfc_pkg.sv */
/*
 types and shared arithmetic for the pulse width trigger block.
 assumes nothing beyond the defs header.
*/
`default_nettype none
package pwtfc_pkg;
   `include "pwtfc_defs.svh"

   typedef enum logic [1:0] {COND_LT, COND_GT, COND_EQ, COND_NE} pwtfc_cond_type;
   typedef enum logic [1:0] {MODE_EDGE, MODE_PULSE, MODE_VIDEO, MODE_OFF} pwtfc_mode_type;

   // ----------------------------------------
   // step quantiser: coarser of one cycle or about one part per thousand
   // ----------------------------------------
   // power-of-two step keeps this cheap; from 1000 up the step never exceeds value/1000
   function automatic logic [31:0] pwtfc_quant(input logic [31:0] x);
      logic [31:0] mask;
      mask = 32'hFFFF_FFFF;
      for (int i = `PWTFC_PPT_SHIFT + 1; i < 32; i++) begin
         if (x[i]) begin
            mask = 32'hFFFF_FFFF << (i - `PWTFC_PPT_SHIFT);
         end
      end
      return x & mask;
   endfunction : pwtfc_quant
endpackage : pwtfc_pkg
`default_nettype wire

/* rtl/pwtfc_top.sv */
/*
 pulse width trigger qualifier and trigger frequency counter.
 assumes trigger comparator levels synchronous to CLK and static settings.
*/
// Operation
// - four width conditions, each on positive or negative pulses
// - equal mode fires at trailing edge when width lies in the band
// - not-equal fires at trailing edge if short, else once width exceeded
// - shorter-than fires at trailing edge of a pulse below set width
// - longer-than fires once pulse outlasts set width, no trailing edge wait
// - width setting clamped to 33 ns through 10 s
// - setting and measurement step is one 4 ns cycle or about one per thousand
// - above 330 ns band is 5 percent plus step, else plus/minus 16.5 ns
// - not-equal 165 to 330 ns band is minus 16.5, plus 33 ns
// - counter runs regardless of acquisition arm or single-shot state
// - pulse mode counts qualifying pulses over a 250 ms gate
// - edge mode counts every edge of the selected polarity
// - counter disabled and result cleared in video mode
// - any trigger source is selectable as counter input
// - works from 10 Hz up, counting over the full gate
// - accuracy limited by clock reference and one count
`timescale 1ns/100ps
`default_nettype none
`include "pwtfc_defs.svh"
module pwtfc_top
   import pwtfc_pkg::*;
#(
   parameter int unsigned GATE_CYC = `PWTFC_GATE_CYC
)
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   input wire logic [3:0] TRIG_SRC,
   input wire logic [1:0] SRC_SEL,
   input wire logic POLARITY,
   input wire logic [1:0] COND,
   input wire logic [1:0] MODE,
   input wire logic [31:0] WIDTH_SET,
   input wire logic ARM,
   output logic TRIG_OUT,
   output logic [31:0] PULSE_WIDTH,
   output logic [31:0] FREQ_COUNT,
   output logic FREQ_VALID,
   output logic FREQ_DONE
);
   // ----------------------------------------
   // source selection and edges
   // ----------------------------------------
   logic level_reg;
   logic level_next;
   logic act_now;
   logic act_prev;
   logic lead;
   logic trail;
   logic [31:0] cnt_reg;
   pwtfc_cond_type cond;
   pwtfc_mode_type mode;

   assign cond = pwtfc_cond_type'(COND);
   assign mode = pwtfc_mode_type'(MODE);
   assign level_next = TRIG_SRC[SRC_SEL];
   // polarity high selects negative pulses
   assign act_now = level_next ^ POLARITY;
   assign act_prev = level_reg ^ POLARITY;
   assign lead = act_now && !act_prev;
   assign trail = !act_now && act_prev;

   pwtfc_width_timer pwtfc_width_timer_inst (
      .clk(CLK),
      .srst(SRST),
      .ce(CE),
      .lead(lead),
      .active(act_now),
      .cnt_reg(cnt_reg)
   );

   // ----------------------------------------
   // width limits
   // ----------------------------------------
   logic [31:0] set_c;
   logic [31:0] set_q;
   logic [31:0] meas_q;
   logic [31:0] pct;
   logic [31:0] band_lo;
   logic [31:0] band_hi;
   logic [31:0] lim_lo;
   logic [31:0] lim_hi;
   logic is_long;
   logic is_mid;

   assign set_c = (WIDTH_SET < `PWTFC_MIN_CYC) ? `PWTFC_MIN_CYC :
                  (WIDTH_SET > `PWTFC_MAX_CYC) ? `PWTFC_MAX_CYC : WIDTH_SET;
   assign set_q = pwtfc_quant(set_c);
   assign meas_q = pwtfc_quant(cnt_reg);
   assign is_long = set_q > `PWTFC_LONG_CYC;
   assign is_mid = set_q > `PWTFC_MID_CYC;
   // 5 percent plus just under one step stays below 5.1 percent plus 16.5 ns
   assign pct = set_q / `PWTFC_PCT_DIV + `PWTFC_STEP_CYC;
   assign band_lo = is_long ? pct : `PWTFC_STEP_CYC;
   assign band_hi = is_long ? pct :
                    (cond == COND_NE && is_mid) ? `PWTFC_NE_HI_CYC : `PWTFC_STEP_CYC;
   assign lim_lo = set_q - band_lo;
   assign lim_hi = set_q + band_hi;

   // ----------------------------------------
   // condition qualification
   // ----------------------------------------
   logic lt_hit;
   logic gt_hit;
   logic eq_hit;
   logic ne_hit;
   logic hit;

   assign lt_hit = trail && (meas_q < set_q);
   // equality to the count happens once per pulse, so no fired flag is needed
   assign gt_hit = act_now && !lead && (cnt_reg == set_q);
   assign eq_hit = trail && (meas_q >= lim_lo) && (meas_q <= lim_hi);
   assign ne_hit = (trail && (meas_q < lim_lo)) ||
                   (act_now && !lead && (cnt_reg == lim_hi));

   always_comb begin
      unique case (cond)
         COND_LT: hit = lt_hit;
         COND_GT: hit = gt_hit;
         COND_EQ: hit = eq_hit;
         COND_NE: hit = ne_hit;
      endcase
   end

   // ----------------------------------------
   // trigger output and last width
   // ----------------------------------------
   logic trig_next;
   logic [31:0] width_next;

   assign trig_next = hit && ARM && (mode == MODE_PULSE);
   assign width_next = trail ? meas_q : PULSE_WIDTH;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         // track the pin in reset so an idle-high source gives no false edge after release
         level_reg <= level_next;
         TRIG_OUT <= 1'b0;
         PULSE_WIDTH <= 32'h0000_0000;
      end else if (CE) begin
         level_reg <= level_next;
         TRIG_OUT <= trig_next;
         PULSE_WIDTH <= width_next;
      end
   end

   // ----------------------------------------
   // frequency counter
   // ----------------------------------------
   logic [31:0] gate_reg;
   logic [31:0] gate_next;
   logic [31:0] evt_reg;
   logic [31:0] evt_next;
   logic [31:0] freq_next;
   logic valid_next;
   logic done_next;
   logic [1:0] mode_reg;
   logic count_evt;
   logic gate_end;
   logic restart;
   logic video;

   assign video = (mode == MODE_VIDEO) || (mode == MODE_OFF);
   // ARM is not looked at: counting goes on while acquisition is idle
   assign count_evt = (mode == MODE_PULSE) ? hit :
                      (mode == MODE_EDGE) ? lead : 1'b0;
   assign restart = (MODE != mode_reg) || video;
   // a full gate keeps the one-count error at 4 Hz, fine for 10 Hz inputs
   assign gate_end = (gate_reg == 32'(GATE_CYC - 1));
   assign gate_next = (restart || gate_end) ? 32'h0000_0000 : gate_reg + 32'h0000_0001;
   assign evt_next = (restart || gate_end) ? 32'h0000_0000 : evt_reg + {31'h0000_0000, count_evt};
   assign freq_next = video ? 32'h0000_0000 :
                      (!restart && gate_end) ? evt_reg + {31'h0000_0000, count_evt} : FREQ_COUNT;
   assign valid_next = video ? 1'b0 : (!restart && gate_end) ? 1'b1 : FREQ_VALID;
   assign done_next = !restart && gate_end;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         gate_reg <= 32'h0000_0000;
         evt_reg <= 32'h0000_0000;
         mode_reg <= 2'h2;
         FREQ_COUNT <= 32'h0000_0000;
         FREQ_VALID <= 1'b0;
         FREQ_DONE <= 1'b0;
      end else if (CE) begin
         gate_reg <= gate_next;
         evt_reg <= evt_next;
         mode_reg <= MODE;
         FREQ_COUNT <= freq_next;
         FREQ_VALID <= valid_next;
         FREQ_DONE <= done_next;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);

   sequence gt_over_seq;
      CE && ARM && mode == MODE_PULSE && cond == COND_GT && act_now && !lead && cnt_reg == set_q;
   endsequence
   sequence ne_over_seq;
      CE && ARM && mode == MODE_PULSE && cond == COND_NE && act_now && !lead && cnt_reg == lim_hi;
   endsequence
   sequence counting_seq;
      CE && !restart && !gate_end;
   endsequence

   chk_lt_trailing: assert property ((CE && ARM && mode == MODE_PULSE && cond == COND_LT && trail
      && meas_q < set_q) |=> TRIG_OUT) else $error("short pulse not triggered");
   chk_gt_timeout: assert property (gt_over_seq |=> TRIG_OUT) else $error("timeout not triggered");
   chk_ne_long: assert property (ne_over_seq |=> TRIG_OUT) else $error("long pulse not triggered");
   chk_eq_outside: assert property ((CE && cond == COND_EQ && trail && meas_q > lim_hi)
      |=> !TRIG_OUT) else $error("wide pulse triggered");
   chk_ne_mid_band: assert property ((cond == COND_NE && set_q > 32'd41 && set_q <= 32'd82)
      |-> (lim_hi == set_q + 32'd8 && lim_lo == set_q - 32'd4)) else $error("bad mid band");
   chk_width_clamp: assert property (set_c >= 32'd9 && set_c <= 32'd2500000000)
      else $error("width out of range");
   chk_edge_count: assert property ((counting_seq and (mode == MODE_EDGE && lead))
      |=> evt_reg == $past(evt_reg) + 32'd1) else $error("edge not counted");
   chk_count_unarmed: assert property ((counting_seq and (mode == MODE_PULSE && hit && !ARM))
      |=> evt_reg == $past(evt_reg) + 32'd1) else $error("count stalled when idle");
   chk_gate_close: assert property ((CE && !restart && gate_end)
      |=> ((FREQ_DONE && FREQ_VALID) and (CE |=> !FREQ_DONE))) else $error("gate did not close");
   chk_video_idle: assert property ((CE && video) |=> (!FREQ_VALID && FREQ_COUNT == 32'd0))
      else $error("counter active in video");
endmodule : pwtfc_top
`default_nettype wire

/* rtl/pwtfc_width_timer.sv */
/*
 width timer: counts active cycles of the current pulse.
 assumes lead and active are combinational strobes synchronous to the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module pwtfc_width_timer
   import pwtfc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic lead,
   input wire logic active,
   output logic [31:0] cnt_reg
);
   logic [31:0] cnt_next;

   // saturating so a stuck level never wraps back into a legal width
   assign cnt_next = lead ? 32'h0000_0001 :
                     (active && (cnt_reg != 32'hFFFF_FFFF)) ? cnt_reg + 32'h0000_0001 : cnt_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_reg <= 32'h0000_0000;
      end else if (ce) begin
         cnt_reg <= cnt_next;
      end
   end

   chk_timer_restart: assert property (@(posedge clk) disable iff (srst)
      (ce && lead) |=> (cnt_reg == 32'h0000_0001)) else $error("timer did not restart");
endmodule : pwtfc_width_timer
`default_nettype wire

/* verif/pwtfc_src_model.sv */
/*
 trigger comparator model: one pulse per go, repeating while go stays high.
 assumes clk is the block clock; sel and pol follow the block settings.
*/
`timescale 1ns/100ps
`default_nettype none
module pwtfc_src_model (
   input wire logic clk,
   input wire logic [1:0] sel,
   input wire logic pol,
   input wire logic go,
   input wire logic [31:0] len,
   input wire logic [31:0] gap,
   output logic [3:0] src,
   output logic act
);
   logic busy_reg = 1'b0;
   logic tog_reg = 1'b0;
   logic [31:0] k_reg = 32'h0000_0000;
   // ----------------------------------------
   // pulse shaping
   // ----------------------------------------
   // unselected lines toggle every cycle, so a wrong source pick shows up
   assign act = busy_reg && (k_reg < len);
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         src[i] = (i == sel) ? (act ^ pol) : (tog_reg ^ i[0]);
      end
   end
   always_ff @(posedge clk) begin
      tog_reg <= ~tog_reg;
      if (!busy_reg) begin
         busy_reg <= go;
         k_reg <= 32'h0000_0000;
      end else if (k_reg == len + gap - 1) begin
         busy_reg <= go;
         k_reg <= 32'h0000_0000;
      end else begin
         k_reg <= k_reg + 1;
      end
   end
endmodule : pwtfc_src_model
`default_nettype wire

/* verif/pwtfc_top_tb.sv */
/*
 self-checking bench: width conditions, bands, clamp and frequency counter.
 assumes a 100 cycle gate in place of the full-length one.
*/
`timescale 1ns/100ps
`default_nettype none
module pwtfc_top_tb;
   import pwtfc_pkg::*;
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic CE = 1'b1;
   logic [3:0] TRIG_SRC;
   logic [1:0] SRC_SEL = 2'h0;
   logic POLARITY = 1'b0;
   logic [1:0] COND = 2'h0;
   logic [1:0] MODE = 2'h1;
   logic [31:0] WIDTH_SET = 32'h0000_0014;
   logic ARM = 1'b1;
   logic TRIG_OUT;
   logic [31:0] PULSE_WIDTH;
   logic [31:0] FREQ_COUNT;
   logic FREQ_VALID;
   logic FREQ_DONE;
   logic go = 1'b0;
   logic act;
   logic [31:0] len = 32'h0000_0003;
   logic [31:0] gap = 32'h0000_0028;
   int n_mismatch = 0;
   int compares = 0;

   pwtfc_top #(.GATE_CYC(100)) pwtfc_top_inst (.CLK(CLK), .SRST(SRST), .CE(CE), .TRIG_SRC(TRIG_SRC),
      .SRC_SEL(SRC_SEL), .POLARITY(POLARITY), .COND(COND), .MODE(MODE), .WIDTH_SET(WIDTH_SET),
      .ARM(ARM), .TRIG_OUT(TRIG_OUT), .PULSE_WIDTH(PULSE_WIDTH), .FREQ_COUNT(FREQ_COUNT),
      .FREQ_VALID(FREQ_VALID), .FREQ_DONE(FREQ_DONE));
   pwtfc_src_model pwtfc_src_model_inst (.clk(CLK), .sel(SRC_SEL), .pol(POLARITY), .go(go),
      .len(len), .gap(gap), .src(TRIG_SRC), .act(act));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial begin
      forever #2 CLK = ~CLK;
   end
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk
   task automatic stop_test;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   // fire offset is counted from the first active cycle; 0 means no trigger
   task automatic run_pulse(input pwtfc_cond_type c, input logic pol, input logic arm,
         input logic [31:0] set, input logic [31:0] n, input logic [31:0] exp_off);
      int a0;
      int f;
      a0 = -1;
      f = -1;
      @(posedge CLK);
      COND <= c;
      POLARITY <= pol;
      ARM <= arm;
      WIDTH_SET <= set;
      len <= n;
      SRC_SEL <= SRC_SEL + 2'h1;
      // settle time hides the glitch a source or polarity switch can make
      repeat (5) @(posedge CLK);
      go <= 1'b1;
      @(posedge CLK);
      go <= 1'b0;
      for (int i = 0; i < n + 60; i++) begin
         @(negedge CLK);
         if (act && a0 < 0) a0 = i;
         if (TRIG_OUT === 1'b1 && f < 0) f = i;
      end
      chk(exp_off, (f < 0) ? 32'h0000_0000 : 32'(f - a0));
      chk(n, PULSE_WIDTH);
   endtask : run_pulse
   task automatic wait_done;
      int i;
      i = 0;
      @(negedge CLK);
      while (FREQ_DONE !== 1'b1 && i < 300) begin
         @(negedge CLK);
         i++;
      end
      chk(1, FREQ_DONE);
   endtask : wait_done

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge CLK);
      SRST <= 1'b0;
      @(negedge CLK);
      chk(0, FREQ_VALID);
      run_pulse(COND_LT, 0, 1, 20, 19, 20);
      run_pulse(COND_LT, 0, 1, 20, 20, 0);
      run_pulse(COND_LT, 1, 1, 20, 10, 11);
      run_pulse(COND_LT, 0, 0, 20, 10, 0);
      run_pulse(COND_LT, 0, 1, 3, 8, 9);
      run_pulse(COND_GT, 0, 1, 20, 30, 21);
      run_pulse(COND_GT, 1, 1, 20, 20, 0);
      run_pulse(COND_EQ, 0, 1, 20, 16, 17);
      run_pulse(COND_EQ, 0, 1, 20, 24, 25);
      run_pulse(COND_EQ, 0, 1, 20, 15, 0);
      run_pulse(COND_EQ, 0, 1, 20, 25, 0);
      run_pulse(COND_EQ, 0, 1, 200, 186, 187);
      run_pulse(COND_EQ, 0, 1, 200, 185, 0);
      run_pulse(COND_NE, 0, 1, 20, 15, 16);
      run_pulse(COND_NE, 0, 1, 20, 30, 25);
      run_pulse(COND_NE, 0, 1, 20, 20, 0);
      run_pulse(COND_NE, 1, 1, 60, 55, 56);
      run_pulse(COND_NE, 0, 1, 60, 80, 69);
      run_pulse(COND_NE, 0, 1, 60, 68, 0);
      @(posedge CLK);
      MODE <= MODE_EDGE;
      POLARITY <= 1'b0;
      len <= 3;
      gap <= 7;
      go <= 1'b1;
      wait_done();
      wait_done();
      chk(10, FREQ_COUNT);
      chk(1, FREQ_VALID);
      @(posedge CLK);
      MODE <= MODE_PULSE;
      COND <= COND_LT;
      WIDTH_SET <= 20;
      ARM <= 1'b0;
      wait_done();
      wait_done();
      chk(10, FREQ_COUNT);
      @(posedge CLK);
      MODE <= MODE_VIDEO;
      repeat (4) @(negedge CLK);
      chk(0, FREQ_VALID);
      chk(0, FREQ_COUNT);
      stop_test();
   end
   // the whole run needs some 2500 cycles
   initial begin
      #80000;
      n_mismatch++;
      stop_test();
   end
endmodule : pwtfc_top_tb
`default_nettype wire
